// ### rtl/cgs_pkg.sv
// Constants, register map and carrier types for the clock generator control block.
// Assumes a 20 MHz system clock and an AHB-Lite master with 32-bit single transfers.
package cgs_pkg;

	// Register byte addresses
	localparam logic [7:0] ADDR_LOOP_CTRL = 8'h00;
	localparam logic [7:0] ADDR_BW_CTRL   = 8'h04;
	localparam logic [7:0] ADDR_MULT      = 8'h08;

	// Loop control register fields
	localparam int LC_IRQ_EN  = 7;
	localparam int LC_IRQ_FLG = 6;
	localparam int LC_PWR_EN  = 5;
	localparam int LC_SRC_SEL = 4;
	localparam logic [3:0] LC_UNUSED_VAL = 4'hF;

	// Bandwidth control register fields
	localparam int BW_AUTO    = 7;
	localparam int BW_LOCK    = 6;
	localparam int BW_TRACK   = 5;

	// Multiplier register field and reset value
	localparam int          MULT_W     = 4;
	localparam logic [3:0]  MULT_RESET = 4'h6;

	// Frequency monitor defaults, in reference cycles and counted VCO edges
	localparam int REF_WIN_DEF  = 16;
	localparam int TRK_TOL_DEF  = 8;
	localparam int LOCK_TOL_DEF = 2;

	// AHB-Lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic [2:0] HSIZE_WORD    = 3'b010;

	typedef struct packed {
		logic irq_en;
		logic irq_flag;
		logic pwr_en;
		logic src_sel;
	} cgs_loop_ctrl_t;

	typedef struct packed {
		logic auto_bw;
		logic trk_manual;
	} cgs_bw_ctrl_t;

	typedef struct packed {
		logic       write;
		logic [7:0] addr;
	} cgs_ahb_req_t;

endpackage

// ### rtl/cgs_div2.sv
// Divide-by-two base clock generator running on edge pulses of the selected source.
// Assumes source edges arrive as one-cycle pulses already synchronised to clk.
`timescale 1ns/1ns
module cgs_div2 import cgs_pkg::*; (
	// Clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// Control
	input  wire logic run,
	input  wire logic src_sel,
	input  wire logic xtal_rise,
	input  wire logic vco_rise,
	// Output
	output logic      base_q
);

	logic edge_sel;

	// Selected source, half frequency
	always_comb begin
		edge_sel = src_sel ? vco_rise : xtal_rise;
	end

	// Held low while the oscillator is off
	always_ff @(posedge clk) begin
		if (srst || !run) begin
			base_q <= 1'b0;
		end else if (edge_sel) begin
			base_q <= ~base_q;
		end
	end

endmodule

// ### rtl/cgs_freq_mon.sv
// Frequency error monitor: counts VCO edges over a window of reference edges.
// Assumes one-cycle edge pulses synchronised to clk; VCO must run below clk/2.
`timescale 1ns/1ns
module cgs_freq_mon import cgs_pkg::*; #(
	parameter int REF_WIN  = REF_WIN_DEF,
	parameter int TRK_TOL  = TRK_TOL_DEF,
	parameter int LOCK_TOL = LOCK_TOL_DEF
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              srst,
	// Inputs
	input  wire logic              enable,
	input  wire logic              xtal_rise,
	input  wire logic              vco_rise,
	input  wire logic [MULT_W-1:0] mult,
	// Status
	output logic                   tracking_q,
	output logic                   settled_q
);

	localparam int CW = $clog2(REF_WIN * 32 + 1);

	logic [CW-1:0] ref_cnt_q;
	logic [CW-1:0] vco_cnt_q;
	logic [CW-1:0] expect_v;
	logic [CW-1:0] err_v;

	generate
		if (REF_WIN < 2 || LOCK_TOL > TRK_TOL) begin : g_bad
			$error("cgs_freq_mon: window or tolerance values unusable");
		end
	endgenerate

	// Multiplier field of zero behaves as one
	always_comb begin
		expect_v = CW'((mult == '0 ? 1 : int'(mult)) * REF_WIN);
		err_v    = (vco_cnt_q > expect_v) ? CW'(vco_cnt_q - expect_v)
		                                  : CW'(expect_v - vco_cnt_q);
	end

	always_ff @(posedge clk) begin
		if (srst || !enable) begin
			ref_cnt_q <= '0;
		end else if (xtal_rise) begin
			ref_cnt_q <= (ref_cnt_q == CW'(REF_WIN - 1)) ? '0 : CW'(ref_cnt_q + 1'b1);
		end
	end

	// Count saturates at twice target, so error never exceeds one hundred percent
	always_ff @(posedge clk) begin
		if (srst || !enable) begin
			vco_cnt_q <= '0;
		end else if (xtal_rise && ref_cnt_q == CW'(REF_WIN - 1)) begin
			vco_cnt_q <= '0;
		end else if (vco_rise && vco_cnt_q < CW'(expect_v << 1)) begin
			vco_cnt_q <= CW'(vco_cnt_q + 1'b1);
		end
	end

	always_ff @(posedge clk) begin
		if (srst || !enable) begin
			tracking_q <= 1'b0;
			settled_q  <= 1'b0;
		end else if (xtal_rise && ref_cnt_q == CW'(REF_WIN - 1)) begin
			tracking_q <= (err_v <= CW'(TRK_TOL));
			settled_q  <= (err_v <= CW'(LOCK_TOL));
		end
	end

endmodule

// ### rtl/cgs_clkgen_ctrl.sv
// Clock generator control and status: AHB-Lite registers, lock interrupt, stop and break
// handling, base clock selection. Clock pins and system control inputs are asynchronous and
// are synchronised here; break and stop controls come from the system integration logic.
//
// Decided for this implementation: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ns
module cgs_clkgen_ctrl import cgs_pkg::*; #(
	parameter int REF_WIN  = REF_WIN_DEF,
	parameter int TRK_TOL  = TRK_TOL_DEF,
	parameter int LOCK_TOL = LOCK_TOL_DEF
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Clock pins
	input  wire logic        xtal_pin,
	input  wire logic        vco_pin,
	// System integration controls
	input  wire logic        osc_run_en,
	input  wire logic        break_active,
	input  wire logic        break_flag_clear_en,
	// Outputs
	output logic             xtal_clock,
	output logic             base_clock_out,
	output logic             clkgen_irq_out
);

	// Synchronisers: stage one is read only by stage two
	logic [1:0] xtal_s_q;
	logic [1:0] vco_s_q;
	logic [1:0] run_s_q;
	logic [1:0] brk_s_q;
	logic [1:0] break_flag_clear_en_s_q;
	logic       xtal_d1_q;
	logic       vco_d1_q;
	logic       run_d1_q;

	logic xtal_rise;
	logic vco_rise;
	logic run;
	logic stop_entry;

	// Registers
	cgs_loop_ctrl_t      lc_q;
	cgs_bw_ctrl_t        bw_q;
	logic [MULT_W-1:0]   mult_q;
	logic                settled_prev_q;

	// Bus phase
	cgs_ahb_req_t        req_q;
	logic                dphase_q;

	// Monitor outputs
	logic mon_tracking;
	logic mon_settled;
	logic settled_ind;
	logic tracking_ind;

	// Decodes
	logic addr_ok;
	logic take;
	logic wr_lc;
	logic wr_bw;
	logic wr_mult;
	logic rd_lc;
	logic flag_protect;
	logic lock_change;
	logic flag_clear;
	logic [31:0] rd_word;

	function automatic logic [31:0] read_mux(input logic [7:0] a, input logic [31:0] lc,
	                                         input logic [31:0] bw, input logic [31:0] mu);
		case (a)
			ADDR_LOOP_CTRL: read_mux = lc;
			ADDR_BW_CTRL:   read_mux = bw;
			ADDR_MULT:      read_mux = mu;
			default:        read_mux = 32'h0000_0000;
		endcase
	endfunction

	generate
		if (REF_WIN < 2) begin : g_bad
			$error("cgs_clkgen_ctrl: reference window too short");
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (srst) begin
			xtal_s_q <= 2'h0;
			vco_s_q  <= 2'h0;
			run_s_q  <= 2'h0;
			brk_s_q  <= 2'h0;
			break_flag_clear_en_s_q <= 2'h0;
		end else begin
			xtal_s_q <= {xtal_s_q[0], xtal_pin};
			vco_s_q  <= {vco_s_q[0], vco_pin};
			run_s_q  <= {run_s_q[0], osc_run_en};
			brk_s_q  <= {brk_s_q[0], break_active};
			break_flag_clear_en_s_q <= {break_flag_clear_en_s_q[0], break_flag_clear_en};
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			xtal_d1_q <= 1'b0;
			vco_d1_q  <= 1'b0;
			run_d1_q  <= 1'b0;
		end else begin
			xtal_d1_q <= xtal_s_q[1];
			vco_d1_q  <= vco_s_q[1];
			run_d1_q  <= run_s_q[1];
		end
	end

	always_comb begin
		run        = run_s_q[1];
		xtal_rise  = xtal_s_q[1] & ~xtal_d1_q & run;
		vco_rise   = vco_s_q[1] & ~vco_d1_q & run & lc_q.pwr_en;
		stop_entry = run_d1_q & ~run;
	end

	// Lock and acquisition status

	cgs_freq_mon #(
		.REF_WIN  (REF_WIN),
		.TRK_TOL  (TRK_TOL),
		.LOCK_TOL (LOCK_TOL)
	) u_mon (
		.clk        (clk),
		.srst       (srst),
		.enable     (bw_q.auto_bw & lc_q.pwr_en & run),
		.xtal_rise  (xtal_rise),
		.vco_rise   (vco_rise),
		.mult       (mult_q),
		.tracking_q (mon_tracking),
		.settled_q  (mon_settled)
	);

	always_comb begin
		settled_ind  = bw_q.auto_bw & mon_settled;
		tracking_ind = bw_q.auto_bw ? mon_tracking : bw_q.trk_manual;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			settled_prev_q <= 1'b0;
		end else begin
			settled_prev_q <= settled_ind;
		end
	end

	// Both directions of change count
	always_comb begin
		lock_change = bw_q.auto_bw & (settled_ind ^ settled_prev_q);
	end

	// AHB-Lite: zero wait states, always OKAY
	always_comb begin
		addr_ok = (haddr[7:0] == ADDR_LOOP_CTRL) || (haddr[7:0] == ADDR_BW_CTRL)
		       || (haddr[7:0] == ADDR_MULT);
		take    = hsel & hready & (htrans == HTRANS_NONSEQ) & (hsize == HSIZE_WORD)
		        & (haddr[31:8] == 24'h00_0000) & addr_ok;
		wr_lc   = dphase_q & req_q.write & (req_q.addr == ADDR_LOOP_CTRL);
		wr_bw   = dphase_q & req_q.write & (req_q.addr == ADDR_BW_CTRL);
		wr_mult = dphase_q & req_q.write & (req_q.addr == ADDR_MULT);
		// Flag clears on the read address phase so read data still shows it set
		rd_lc   = take & ~hwrite & (haddr[7:0] == ADDR_LOOP_CTRL);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			dphase_q <= 1'b0;
			req_q    <= '0;
		end else begin
			dphase_q <= take & hwrite;
			if (take) begin
				req_q.write <= hwrite;
				req_q.addr  <= haddr[7:0];
			end
		end
	end

	always_comb begin
		rd_word = read_mux(haddr[7:0],
		                   {24'h00_0000, lc_q.irq_en, lc_q.irq_flag & bw_q.auto_bw,
		                    lc_q.pwr_en, lc_q.src_sel, LC_UNUSED_VAL},
		                   {24'h00_0000, bw_q.auto_bw, settled_ind, tracking_ind, 5'h00},
		                   {28'h000_0000, mult_q});
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (take && !hwrite) begin
				hrdata <= rd_word;
			end
		end
	end

	// Break protection of the flag
	always_comb begin
		flag_protect = brk_s_q[1] & ~break_flag_clear_en_s_q[1];
		flag_clear   = rd_lc & ~flag_protect;
	end

	// Flag: a change in the same cycle as a clearing read wins; set regardless of enable
	always_ff @(posedge clk) begin
		if (srst) begin
			lc_q.irq_flag <= 1'b0;
		end else if (!bw_q.auto_bw) begin
			lc_q.irq_flag <= 1'b0;
		end else if (lock_change) begin
			lc_q.irq_flag <= 1'b1;
		end else if (flag_clear) begin
			lc_q.irq_flag <= 1'b0;
		end
	end

	// Enable is writable only in automatic mode and reads as zero otherwise
	always_ff @(posedge clk) begin
		if (srst) begin
			lc_q.irq_en <= 1'b0;
		end else if (!bw_q.auto_bw) begin
			lc_q.irq_en <= 1'b0;
		end else if (wr_lc) begin
			lc_q.irq_en <= hwdata[LC_IRQ_EN];
		end
	end

	// Power cannot be cleared while the VCO drives the base clock
	always_ff @(posedge clk) begin
		if (srst) begin
			lc_q.pwr_en <= 1'b1;
		end else if (wr_lc && (hwdata[LC_PWR_EN] || !lc_q.src_sel)) begin
			lc_q.pwr_en <= hwdata[LC_PWR_EN];
		end
	end

	// Source select: stop clears it, lock is not checked
	always_ff @(posedge clk) begin
		if (srst) begin
			lc_q.src_sel <= 1'b0;
		end else if (stop_entry || !run) begin
			lc_q.src_sel <= 1'b0;
		end else if (wr_lc && (lc_q.pwr_en || !hwdata[LC_SRC_SEL])) begin
			lc_q.src_sel <= hwdata[LC_SRC_SEL];
		end
	end

	// Manual tracking value is kept while automatic mode hides it
	always_ff @(posedge clk) begin
		if (srst) begin
			bw_q <= '0;
		end else if (wr_bw) begin
			bw_q.auto_bw <= hwdata[BW_AUTO];
			if (!bw_q.auto_bw) begin
				bw_q.trk_manual <= hwdata[BW_TRACK];
			end
		end
	end

	// Multiplier is frozen while the loop is powered
	always_ff @(posedge clk) begin
		if (srst) begin
			mult_q <= MULT_RESET;
		end else if (wr_mult && !lc_q.pwr_en) begin
			mult_q <= hwdata[MULT_W-1:0];
		end
	end

	// Outputs. No wait-mode input exists: wait leaves everything running

	cgs_div2 u_div (
		.clk       (clk),
		.srst      (srst),
		.run       (run),
		.src_sel   (lc_q.src_sel),
		.xtal_rise (xtal_rise),
		.vco_rise  (vco_rise),
		.base_q    (base_clock_out)
	);

	always_ff @(posedge clk) begin
		if (srst) begin
			xtal_clock <= 1'b0;
		end else begin
			xtal_clock <= xtal_s_q[1] & run;
		end
	end

	// Level output, only in automatic mode and while running
	always_ff @(posedge clk) begin
		if (srst) begin
			clkgen_irq_out <= 1'b0;
		end else begin
			clkgen_irq_out <= lc_q.irq_flag & lc_q.irq_en & bw_q.auto_bw & run;
		end
	end

endmodule

// ### verification/cgs_clkgen_ctrl_properties.sv
// Port-level checks for the clock generator control block.
// Assumes hready is tied to hreadyout and break inputs stay steady around accesses.
`timescale 1ns/1ns
module cgs_ctrl_props import cgs_pkg::*; (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// Bus
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	// System controls
	input  wire logic        osc_run_en,
	input  wire logic        break_active,
	input  wire logic        break_flag_clear_en,
	// Outputs
	input  wire logic        xtal_clock,
	input  wire logic        base_clock_out,
	input  wire logic        clkgen_irq_out
);
	logic       tk;
	logic       rd_ctl;
	logic       wr_dp_q;
	logic       rd_dp_q;
	logic       auto_q;
	logic       vco_q;
	logic [7:0] wa_q;
	logic [3:0] run_h_q;
	logic [3:0] brk_h_q;
	logic [3:0] bce_h_q;
	logic [7:0] xh_q;

	assign tk = hsel && hready && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD;
	assign rd_ctl = tk && !hwrite && haddr == {24'h000000, ADDR_LOOP_CTRL};

	// Histories cover the two-flop synchronisers inside the block
	always_ff @(posedge clk) begin
		if (srst) begin
			run_h_q <= 4'h0;
			brk_h_q <= 4'h0;
			bce_h_q <= 4'h0;
			xh_q    <= 8'h00;
		end else begin
			run_h_q <= {run_h_q[2:0], osc_run_en};
			brk_h_q <= {brk_h_q[2:0], break_active};
			bce_h_q <= {bce_h_q[2:0], break_flag_clear_en};
			xh_q    <= {xh_q[6:0], xtal_clock};
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wr_dp_q <= 1'b0;
			rd_dp_q <= 1'b0;
			wa_q    <= 8'h00;
		end else if (hready) begin
			wr_dp_q <= tk && hwrite;
			rd_dp_q <= rd_ctl;
			wa_q    <= haddr[7:0];
		end
	end

	// Shadow of the mode bits; a refused source write only makes the check more lenient
	always_ff @(posedge clk) begin
		if (srst) begin
			auto_q <= 1'b0;
			vco_q  <= 1'b0;
		end else begin
			if (wr_dp_q && wa_q == ADDR_BW_CTRL)
				auto_q <= hwdata[BW_AUTO];
			if (wr_dp_q && wa_q == ADDR_LOOP_CTRL)
				vco_q <= hwdata[LC_SRC_SEL];
			else if (!osc_run_en)
				vco_q <= 1'b0;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_irq_low;
		##2 !clkgen_irq_out;
	endsequence
	sequence s_irq_kept;
		##2 clkgen_irq_out;
	endsequence

	a_stop_quiet: assert property (!osc_run_en [*5] |->
		!xtal_clock && !base_clock_out && !clkgen_irq_out) else $error("outputs live in stop");
	a_read_clears: assert property (rd_ctl && brk_h_q == 4'h0 && !break_active
		&& clkgen_irq_out |-> s_irq_low) else $error("control read left irq set");
	a_brk_keeps: assert property (rd_ctl && (&brk_h_q) && bce_h_q == 4'h0
		&& clkgen_irq_out |-> s_irq_kept) else $error("protected break read cleared irq");
	a_brk_clears: assert property (rd_ctl && (&brk_h_q) && (&bce_h_q)
		&& clkgen_irq_out |-> s_irq_low) else $error("break read with clear enable kept irq");
	a_irq_holds: assert property (clkgen_irq_out && !tk && !$past(tk) && !$past(tk, 2)
		&& (&run_h_q) && osc_run_en |=> clkgen_irq_out) else $error("irq dropped on its own");
	a_manual_quiet: assert property (!auto_q && !$past(auto_q) |->
		!clkgen_irq_out) else $error("irq in manual mode");
	a_manual_flag0: assert property (rd_dp_q && !$past(auto_q) |->
		!hrdata[LC_IRQ_FLG]) else $error("flag read as set in manual mode");
	a_irq_auto_only: assert property ($rose(clkgen_irq_out) |->
		$past(auto_q) && $past(auto_q, 2)) else $error("irq rose outside automatic mode");
	a_base_xtal: assert property ($changed(base_clock_out) && (&run_h_q) && osc_run_en
		&& !vco_q && !$past(vco_q, 4) |-> |({xh_q[6:0], xtal_clock} & ~xh_q))
		else $error("base clock moved without crystal edge");
endmodule

bind cgs_clkgen_ctrl cgs_ctrl_props u_props (.clk(clk), .srst(srst), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hready), .hrdata(hrdata), .osc_run_en(osc_run_en), .break_active(break_active),
	.break_flag_clear_en(break_flag_clear_en), .xtal_clock(xtal_clock),
	.base_clock_out(base_clock_out), .clkgen_irq_out(clkgen_irq_out));

// ### verification/cgs_pin_model.sv
// Free-running crystal and VCO pin source standing in for oscillator and loop.
// Assumes rates in clk cycles; halves stay long enough for the pin synchronisers.
`timescale 1ns/1ns
module cgs_pin_model #(
	parameter int XTAL_HALF = 30
) (
	// Clock
	input  wire logic       clk,
	// Rate of the loop output, half period in clk cycles
	input  wire logic [3:0] vco_half,
	// Pins
	output logic            xtal_pin,
	output logic            vco_pin
);
	int   x_cnt = 0;
	int   v_cnt = 0;
	logic [3:0] vh;
	logic       xp = 1'b0;
	logic       vp = 1'b0;

	// One driver per pin; the toggling state lives in xp and vp
	assign xtal_pin = xp;
	assign vco_pin  = vp;

	// Clamped so the start error never exceeds the wanted rate itself
	assign vh = (vco_half < 4'h3) ? 4'h3 : (vco_half > 4'hA) ? 4'hA : vco_half;

	always @(posedge clk) begin
		x_cnt <= (x_cnt + 1 >= XTAL_HALF) ? 0 : x_cnt + 1;
		v_cnt <= (v_cnt + 1 >= int'(vh)) ? 0 : v_cnt + 1;
		if (x_cnt + 1 >= XTAL_HALF)
			xp <= ~xp;
		if (v_cnt + 1 >= int'(vh))
			vp <= ~vp;
	end
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the clock generator control block over AHB-Lite.
// Assumes the pin model as oscillator and loop; window shortened to four crystal edges.
`timescale 1ns/1ns
module tb_top import cgs_pkg::*;;
	localparam logic [31:0] ALL = 32'hFFFFFFFF;
	localparam logic [31:0] PW  = 32'h1 << LC_PWR_EN;
	localparam logic [31:0] EN  = 32'h1 << LC_IRQ_EN;
	localparam logic [31:0] FL  = 32'h1 << LC_IRQ_FLG;
	localparam logic [31:0] SRC = 32'h1 << LC_SRC_SEL;
	localparam logic [31:0] RLC = 32'h0000000F | PW;
	localparam logic [31:0] AU  = 32'h1 << BW_AUTO;
	localparam logic [31:0] LK  = 32'h1 << BW_LOCK;
	localparam logic [31:0] TK  = 32'h1 << BW_TRACK;
	localparam logic [31:0] MR  = {28'h0000000, MULT_RESET};

	logic        clk, srst, hsel, hwrite, hreadyout, hresp, rd_next;
	logic        osc_run_en, break_active, break_flag_clear_en;
	logic        xtal_pin, vco_pin, xtal_clock, base_clock_out, clkgen_irq_out;
	logic [31:0] haddr, hwdata, hrdata, v;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [3:0]  vco_half;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	int          num_errors = 0;
	int          total_checks = 0;
	integer      seed = 32'hadfa;

	cgs_clkgen_ctrl #(.REF_WIN(4)) DUT (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .xtal_pin(xtal_pin),
		.vco_pin(vco_pin), .osc_run_en(osc_run_en), .break_active(break_active),
		.break_flag_clear_en(break_flag_clear_en), .xtal_clock(xtal_clock),
		.base_clock_out(base_clock_out), .clkgen_irq_out(clkgen_irq_out));
	cgs_pin_model u_pins (.clk(clk), .vco_half(vco_half), .xtal_pin(xtal_pin),
		.vco_pin(vco_pin));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic finish_test;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic fail(input string m);
		num_errors++;
		$display("BAD %0t %s", $time, m);
	endtask

	task automatic cmp_rd(input logic [31:0] got, input logic [31:0] e, input logic [31:0] m);
		total_checks++;
		if ((got & m) !== (e & m))
			fail($sformatf("read %h expected %h", got, e));
		// The slave never signals an error response
		if (hresp !== 1'b0)
			fail("error response");
	endtask

	task automatic cmp_pin(input logic got, input logic e);
		total_checks++;
		if (got !== e)
			fail("output level");
	endtask

	task automatic wait_hr;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			fail("bus hang");
			finish_test;
		end
	endtask

	// Entered right after a rising edge; the expectation is noted once the address is taken
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] e, input logic [31:0] m);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, a};
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		wait_hr;
		htrans <= 2'b00;
		hwdata <= d;
		if (!w) begin
			exp_q.push_back(e);
			msk_q.push_back(m);
		end
		wait_hr;
	endtask

	task automatic wait_irq(input logic lvl);
		int n;
		n = 0;
		while (clkgen_irq_out !== lvl && n < 3000) begin
			@(posedge clk);
			n++;
		end
		if (clkgen_irq_out !== lvl) begin
			fail("irq wait");
			finish_test;
		end
	endtask

	always @(posedge clk) begin
		if (rd_next && hreadyout) begin
			if (exp_q.size() == 0)
				fail("read without note");
			else
				cmp_rd(hrdata, exp_q.pop_front(), msk_q.pop_front());
		end
		if (hreadyout)
			rd_next <= hsel && htrans == HTRANS_NONSEQ && !hwrite;
	end

	initial begin
		#(50 * 100000);
		fail("run limit");
		finish_test;
	end

	initial begin
		srst = 1'b1;
		{hsel, hwrite, break_active, break_flag_clear_en} = 4'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		htrans = 2'b00;
		hsize = HSIZE_WORD;
		osc_run_en = 1'b1;
		vco_half = 4'h8;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		bus(1'b0, ADDR_LOOP_CTRL, 0, RLC, ALL);
		bus(1'b0, ADDR_BW_CTRL, 0, 0, ALL);
		bus(1'b1, ADDR_BW_CTRL, TK, 0, 0);
		bus(1'b0, ADDR_BW_CTRL, 0, TK, ALL);
		bus(1'b0, ADDR_MULT, 0, MR, ALL);
		bus(1'b1, ADDR_LOOP_CTRL, EN | PW | SRC, 0, 0);
		bus(1'b0, ADDR_LOOP_CTRL, 0, RLC | SRC, ALL);
		osc_run_en <= 1'b0;
		repeat (6) @(posedge clk);
		cmp_pin(xtal_clock, 1'b0);
		cmp_pin(base_clock_out, 1'b0);
		cmp_pin(clkgen_irq_out, 1'b0);
		osc_run_en <= 1'b1;
		repeat (6) @(posedge clk);
		bus(1'b0, ADDR_LOOP_CTRL, 0, RLC, ALL);
		v = $random(seed);
		bus(1'b1, ADDR_MULT, v, 0, 0);
		bus(1'b0, ADDR_MULT, 0, MR, ALL);
		bus(1'b1, ADDR_LOOP_CTRL, 0, 0, 0);
		bus(1'b1, ADDR_MULT, v, 0, 0);
		bus(1'b1, 8'h0C + {1'b0, v[6:2], 2'b00}, ALL, 0, 0);
		bus(1'b0, ADDR_MULT, 0, {28'h0000000, v[3:0]}, ALL);
		bus(1'b0, ADDR_LOOP_CTRL, 0, 32'h0000000F, ALL);
		bus(1'b1, ADDR_MULT, MR, 0, 0);
		vco_half <= 4'h5;
		bus(1'b1, ADDR_BW_CTRL, AU, 0, 0);
		bus(1'b1, ADDR_LOOP_CTRL, PW | EN, 0, 0);
		wait_irq(1'b1);
		bus(1'b0, ADDR_BW_CTRL, 0, AU | LK | TK, ALL);
		break_active <= 1'b1;
		repeat (4) @(posedge clk);
		bus(1'b0, ADDR_LOOP_CTRL, 0, RLC | EN | FL, ALL);
		cmp_pin(clkgen_irq_out, 1'b1);
		break_flag_clear_en <= 1'b1;
		repeat (4) @(posedge clk);
		bus(1'b0, ADDR_LOOP_CTRL, 0, RLC | EN | FL, ALL);
		break_active <= 1'b0;
		break_flag_clear_en <= 1'b0;
		repeat (4) @(posedge clk);
		cmp_pin(clkgen_irq_out, 1'b0);
		bus(1'b0, ADDR_LOOP_CTRL, 0, RLC | EN, ALL);
		vco_half <= 4'h8;
		wait_irq(1'b1);
		bus(1'b1, ADDR_BW_CTRL, AU | LK | TK, 0, 0);
		bus(1'b0, ADDR_BW_CTRL, 0, AU, AU | LK);
		bus(1'b0, ADDR_LOOP_CTRL, 0, RLC | EN | FL, ALL);
		@(posedge clk);
		cmp_pin(clkgen_irq_out, 1'b0);
		bus(1'b1, ADDR_LOOP_CTRL, PW, 0, 0);
		vco_half <= 4'h5;
		// Three monitor windows of four crystal periods each
		repeat (3 * 4 * 60) @(posedge clk);
		cmp_pin(clkgen_irq_out, 1'b0);
		bus(1'b0, ADDR_LOOP_CTRL, 0, RLC | FL, ALL);
		finish_test;
	end
endmodule
